// ### rtl/fifo_flag_pkg.sv
// Constants and types shared by the FIFO status flag logic
package fifo_flag_pkg;
    localparam int AW = 20;
    localparam int PW = AW + 1;
    localparam logic [PW-1:0] DEPTH_DEF = 21'h080000;
    localparam logic [AW-1:0] EOFS_RST = 20'h0007F;
    localparam logic [AW-1:0] FOFS_RST = 20'h0007F;
    localparam logic [7:0] A_EOFS = 8'h00;
    localparam logic [7:0] A_FOFS = 8'h04;
    localparam logic [7:0] A_STAT = 8'h08;
    localparam logic [7:0] A_ISTAT = 8'h0C;
    localparam logic [7:0] A_IMASK = 8'h10;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [3:0] PIN_RST = 4'h3;
    // Flag set as on the pins; active low, except empty and full in lookahead mode
    typedef struct packed {
        logic paeN;
        logic pafN;
        logic fullN;
        logic emptyN;
    } flags_t;
endpackage

// ### rtl/fifo_status_flag_logic.sv
// Status flag logic of one die of a deep FIFO, with an AXI4-Lite register port
`timescale 1ns/100ps
module fifo_status_flag_logic #(
    parameter logic [fifo_flag_pkg::PW-1:0] DEPTH = fifo_flag_pkg::DEPTH_DEF
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic master_reset_n,
    input wire logic partial_reset_n,
    input wire logic flag_timing_select,
    input wire logic lookahead_mode,
    input wire logic wrTick,
    input wire logic wrReq,
    input wire logic rdTick,
    input wire logic rdReq,
    input wire logic markReq,
    input wire logic retransmitActive,
    output logic empty_indicator_n,
    output logic full_indicator_n,
    output logic almost_full_indicator_n,
    output logic almost_empty_indicator_n,
    output logic irq,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);
    import fifo_flag_pkg::*;

    // Byte-lane merge used by every writable register
    function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
            if (s[i]) r[i*8 +: 8] = nw[i*8 +: 8];
        return r;
    endfunction

    // ----------------------------------------
    // Pin synchronisers and mode capture
    // ----------------------------------------
    logic [3:0] pinS1_q, pinS2_q;
    logic la_q, ptSel_q;
    wire logic mrsN = pinS2_q[0];
    wire logic clear = ~pinS2_q[0] | ~pinS2_q[1];

    // Mode straps follow the pins only while master reset is held
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pinS1_q <= PIN_RST;
            pinS2_q <= PIN_RST;
            la_q <= 1'b0;
            ptSel_q <= 1'b0;
        end
        else if (ce)
        begin
            pinS1_q <= {flag_timing_select, lookahead_mode, partial_reset_n, master_reset_n};
            pinS2_q <= pinS1_q;
            if (!mrsN)
            begin
                ptSel_q <= pinS2_q[3];
                la_q <= pinS2_q[2];
            end
        end
    end

    // ----------------------------------------
    // Pointers and fill levels
    // ----------------------------------------
    logic [PW-1:0] wrPtr_q, rdPtr_q, markPtr_q;
    logic outValid_q;
    logic [31:0] eOfs_q, fOfs_q, intStat_q, intMask_q;
    wire logic [PW-1:0] laWord = {{AW{1'b0}}, la_q & outValid_q};
    wire logic [PW-1:0] memCnt = wrPtr_q - rdPtr_q;
    wire logic [PW-1:0] level = memCnt + laWord;
    wire logic [PW-1:0] cap = DEPTH + {{AW{1'b0}}, la_q};
    wire logic atCap = (level == cap);
    wire logic wrGo = wrTick & wrReq & ~atCap;
    // Standard reads need a stored word; lookahead loads the output word itself
    wire logic rdStd = ~la_q & rdTick & rdReq & (memCnt != '0);
    wire logic rdLoad = la_q & rdTick & (memCnt != '0) & (~outValid_q | rdReq);
    // The marked position stands in for the read pointer while retransmit runs
    wire logic [PW-1:0] pafLevel = (retransmitActive ? wrPtr_q - markPtr_q : memCnt)
                                   + laWord;
    wire logic [PW-1:0] mOfs = {1'b0, fOfs_q[AW-1:0]};
    wire logic [PW-1:0] nOfs = {1'b0, eOfs_q[AW-1:0]};
    wire logic pafCond = (pafLevel >= cap - mOfs);
    wire logic paeCond = (level <= nOfs + {{AW{1'b0}}, la_q});

    // Pointer and output-word state
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            markPtr_q <= '0;
            outValid_q <= 1'b0;
        end
        else if (ce)
        begin
            if (clear)
            begin
                wrPtr_q <= '0;
                rdPtr_q <= '0;
                markPtr_q <= '0;
                outValid_q <= 1'b0;
            end
            else
            begin
                if (wrGo) wrPtr_q <= wrPtr_q + 1'b1;
                if (rdStd | rdLoad) rdPtr_q <= rdPtr_q + 1'b1;
                if (markReq) markPtr_q <= rdPtr_q;
                // Last word read with nothing behind it: output word empties
                if (rdLoad) outValid_q <= 1'b1;
                else if (la_q & rdTick & rdReq) outValid_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Flag pipelines
    // ----------------------------------------
    logic [2:0] emptyPipe_q;
    logic [1:0] fullPipe_q;
    flags_t flags_q;
    wire logic emptyRaw = la_q ? ~outValid_q : (memCnt != '0);
    wire logic fullRaw = la_q ? atCap : ~atCap;

    // Empty is retimed on read edges, full on write edges
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            emptyPipe_q <= '0;
            fullPipe_q <= '1;
        end
        else if (ce)
        begin
            if (clear)
            begin
                emptyPipe_q <= {3{la_q}};
                fullPipe_q <= {2{~la_q}};
            end
            else
            begin
                if (rdTick) emptyPipe_q <= {emptyPipe_q[1:0], emptyRaw};
                if (wrTick) fullPipe_q <= {fullPipe_q[0], fullRaw};
            end
        end
    end

    // Almost flags; in async timing the assert edge wins a tie with the release
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            almost_full_indicator_n <= 1'b1;
            almost_empty_indicator_n <= 1'b0;
        end
        else if (ce)
        begin
            if (clear)
            begin
                almost_full_indicator_n <= 1'b1;
                almost_empty_indicator_n <= 1'b0;
            end
            else if (ptSel_q)
            begin
                if (wrTick) almost_full_indicator_n <= ~pafCond;
                if (rdTick) almost_empty_indicator_n <= ~paeCond;
            end
            else
            begin
                if (wrTick & pafCond) almost_full_indicator_n <= 1'b0;
                else if (rdTick & ~pafCond) almost_full_indicator_n <= 1'b1;
                if (rdTick & paeCond) almost_empty_indicator_n <= 1'b0;
                else if (wrTick & ~paeCond) almost_empty_indicator_n <= 1'b1;
            end
        end
    end

    assign empty_indicator_n = la_q ? emptyPipe_q[2] : emptyPipe_q[1];
    assign full_indicator_n = fullPipe_q[1];
    assign flags_q = '{almost_empty_indicator_n, almost_full_indicator_n,
                       full_indicator_n, empty_indicator_n};

    // ----------------------------------------
    // AXI4-Lite slave and interrupt
    // ----------------------------------------
    logic [7:0] awAddr_q;
    logic [31:0] wData_q;
    logic [3:0] wStrb_q, actPrev_q;
    wire logic doWrite = ~awready & ~wready & ~bvalid;
    wire logic mapped = (awAddr_q == A_EOFS) | (awAddr_q == A_FOFS) | (awAddr_q == A_STAT)
                        | (awAddr_q == A_ISTAT) | (awAddr_q == A_IMASK);
    // Active sense of each flag; lookahead flips empty and full polarity
    wire logic [3:0] actNow = {~flags_q.paeN, ~flags_q.pafN,
                               la_q ? flags_q.fullN : ~flags_q.fullN,
                               la_q ? flags_q.emptyN : ~flags_q.emptyN};
    wire logic [3:0] evt = actNow & ~actPrev_q;
    wire logic [31:0] clrMask = (doWrite && awAddr_q == A_ISTAT)
                                ? laneMerge(32'h0, wData_q, wStrb_q) : 32'h0;
    wire logic [31:0] intStat_d = (intStat_q & ~clrMask) | {28'h0, evt};
    // Merged write data per register; a call result cannot be part-selected
    wire logic [31:0] eOfsMerge = laneMerge(eOfs_q, wData_q, wStrb_q);
    wire logic [31:0] fOfsMerge = laneMerge(fOfs_q, wData_q, wStrb_q);
    wire logic [31:0] maskMerge = laneMerge(intMask_q, wData_q, wStrb_q);
    wire logic [31:0] rdMux = (araddr == A_EOFS) ? eOfs_q :
                              (araddr == A_FOFS) ? fOfs_q :
                              (araddr == A_STAT) ? {3'h0, level, 2'h0, ptSel_q, la_q, flags_q} :
                              (araddr == A_ISTAT) ? intStat_q :
                              (araddr == A_IMASK) ? intMask_q : 32'h0;
    wire logic rdMapped = (araddr == A_EOFS) | (araddr == A_FOFS) | (araddr == A_STAT)
                          | (araddr == A_ISTAT) | (araddr == A_IMASK);

    // Write channel: address and data taken in either order, one write in flight
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            awready <= 1'b1;
            wready <= 1'b1;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            awAddr_q <= '0;
            wData_q <= '0;
            wStrb_q <= '0;
            eOfs_q <= {12'h0, EOFS_RST};
            fOfs_q <= {12'h0, FOFS_RST};
            intMask_q <= '0;
        end
        else if (ce)
        begin
            if (awvalid & awready)
            begin
                awready <= 1'b0;
                awAddr_q <= awaddr;
            end
            if (wvalid & wready)
            begin
                wready <= 1'b0;
                wData_q <= wdata;
                wStrb_q <= wstrb;
            end
            if (doWrite)
            begin
                bvalid <= 1'b1;
                bresp <= mapped ? RESP_OKAY : RESP_SLVERR;
                if (awAddr_q == A_EOFS)
                    eOfs_q <= {12'h0, eOfsMerge[AW-1:0]};
                if (awAddr_q == A_FOFS)
                    fOfs_q <= {12'h0, fOfsMerge[AW-1:0]};
                if (awAddr_q == A_IMASK)
                    intMask_q <= {28'h0, maskMerge[3:0]};
            end
            if (bvalid & bready)
            begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
            // Master reset restores default offsets; partial reset keeps them
            if (!mrsN)
            begin
                eOfs_q <= {12'h0, EOFS_RST};
                fOfs_q <= {12'h0, FOFS_RST};
            end
        end
    end

    // Read channel and sticky status; a new event beats a clear in the same cycle
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= RESP_OKAY;
            intStat_q <= '0;
            actPrev_q <= 4'h9; // Matches the reset flag sense, so no false event
            irq <= 1'b0;
        end
        else if (ce)
        begin
            if (arvalid & arready)
            begin
                arready <= 1'b0;
                rvalid <= 1'b1;
                rdata <= rdMux;
                rresp <= rdMapped ? RESP_OKAY : RESP_SLVERR;
            end
            else if (rvalid & rready)
            begin
                rvalid <= 1'b0;
                arready <= 1'b1;
            end
            actPrev_q <= actNow;
            intStat_q <= intStat_d;
            irq <= |(intStat_d & intMask_q);
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    chk_empty_std: assert property (@(posedge clk) disable iff (!nrst)
        (ce && rdTick && !la_q && !clear && memCnt == '0) |=> !emptyPipe_q[0])
        else $error("empty not flagged in standard mode");
    chk_valid_hold: assert property (@(posedge clk) disable iff (!nrst)
        (ce && !clear && la_q && rdTick && !rdReq && outValid_q) |=> outValid_q)
        else $error("output word lost without a read");
    chk_read_ignored: assert property (@(posedge clk) disable iff (!nrst)
        (ce && !clear && la_q && !outValid_q && memCnt == '0) |=> $stable(rdPtr_q))
        else $error("read taken while no word valid");
    chk_empty_stages: assert property (@(posedge clk) disable iff (!nrst)
        (ce && rdTick && !clear) |=> emptyPipe_q[1] == $past(emptyPipe_q[0]))
        else $error("empty pipeline did not shift");
    chk_paf_sync: assert property (@(posedge clk) disable iff (!nrst)
        (ce && ptSel_q && wrTick && !clear && pafCond) |=> !almost_full_indicator_n)
        else $error("almost-full missed at threshold");
    chk_paf_edges: assert property (@(posedge clk) disable iff (!nrst)
        ($rose(almost_full_indicator_n) && !ptSel_q && !$past(clear))
        |-> $past(rdTick && ce))
        else $error("almost-full released off a read edge");
    chk_pae_edges: assert property (@(posedge clk) disable iff (!nrst)
        ($rose(almost_empty_indicator_n) && !ptSel_q && !$past(clear))
        |-> $past(wrTick && ce))
        else $error("almost-empty released off a write edge");
    chk_pae_sync: assert property (@(posedge clk) disable iff (!nrst)
        ($changed(almost_empty_indicator_n) && ptSel_q && !$past(clear))
        |-> $past(rdTick && ce))
        else $error("almost-empty moved off a read edge");
    chk_full_block: assert property (@(posedge clk) disable iff (!nrst)
        (ce && !clear && level == cap) |=> $stable(wrPtr_q))
        else $error("write accepted while full");
endmodule

// ### verification/flag_merge_model.sv
// Model of the outside logic that merges the flags of the two dies
`timescale 1ns/100ps
module flag_merge_model (
    input wire logic lookahead_mode,
    input wire fifo_flag_pkg::flags_t dieA,
    input wire fifo_flag_pkg::flags_t dieB,
    output logic emptyAll,
    output logic fullAll,
    output logic [1:0] paeEach,
    output logic [1:0] pafEach
);
    import fifo_flag_pkg::*;
    // One gate per pair hides the skew between dies; only the merged level is used
    assign emptyAll = lookahead_mode ? (dieA.emptyN | dieB.emptyN) : (dieA.emptyN & dieB.emptyN);
    assign fullAll = lookahead_mode ? (dieA.fullN | dieB.fullN) : (dieA.fullN & dieB.fullN);
    // Almost flags stay apart so each die may carry its own threshold
    assign paeEach = {dieB.paeN, dieA.paeN};
    assign pafEach = {dieB.pafN, dieA.pafN};
endmodule

// ### verification/fifo_status_flag_logic_tb.sv
// Self-checking bench for the FIFO status flag logic
`timescale 1ns/100ps
module fifo_status_flag_logic_tb;
    import fifo_flag_pkg::*;
    logic clk = 1'h0, nrst = 1'h0, ce = 1'h1, master_reset_n = 1'h1, partial_reset_n = 1'h1;
    logic flag_timing_select = 1'h0, lookahead_mode = 1'h0, markReq = 1'h0;
    logic wrTick = 1'h0, wrReq = 1'h0, rdTick = 1'h0, rdReq = 1'h0, retransmitActive = 1'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rdVal;
    logic [3:0] wstrb = 4'hF;
    logic empty_indicator_n, full_indicator_n, almost_full_indicator_n, almost_empty_indicator_n;
    logic irq, awready, wready, bvalid, arready, rvalid, emptyAll, fullAll;
    logic [1:0] paeEach, pafEach;
    logic [1:0] bresp, rresp, respVal;
    flags_t die;
    int errTotal = 0, checksDone = 0, cycles = 0;

    // ----------------------------------------
    // Clock, design and partner
    // ----------------------------------------
    always #12.5 clk = ~clk;
    assign die = {almost_empty_indicator_n, almost_full_indicator_n, full_indicator_n,
        empty_indicator_n};
    // Small depth keeps the fill tests short
    fifo_status_flag_logic #(.DEPTH(21'h000010)) u_dut (
        .clk(clk), .nrst(nrst), .ce(ce), .master_reset_n(master_reset_n),
        .partial_reset_n(partial_reset_n), .flag_timing_select(flag_timing_select),
        .lookahead_mode(lookahead_mode), .wrTick(wrTick), .wrReq(wrReq), .rdTick(rdTick),
        .rdReq(rdReq), .markReq(markReq), .retransmitActive(retransmitActive),
        .empty_indicator_n(empty_indicator_n), .full_indicator_n(full_indicator_n),
        .almost_full_indicator_n(almost_full_indicator_n),
        .almost_empty_indicator_n(almost_empty_indicator_n), .irq(irq),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready));
    flag_merge_model u_merge (.lookahead_mode(lookahead_mode), .dieA(die), .dieB(die),
        .emptyAll(emptyAll), .fullAll(fullAll), .paeEach(paeEach), .pafEach(pafEach));

    // ----------------------------------------
    // Checking and access tasks
    // ----------------------------------------
    task automatic final_report();
        $display("checks %0d mismatches %0d", checksDone, errTotal);
        if (errTotal == 0 && checksDone > 0)
        begin
            $display("Testbench passed");
        end
        else
        begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checksDone++;
        if (seen !== exp)
        begin
            errTotal++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic fl(input logic seen, input logic exp);
        chk({31'h0, seen}, {31'h0, exp});
    endtask
    // Write holds each channel until its own ready, then waits for the response
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do
        begin
            @(posedge clk);
            if (awready === 1'h1) awvalid <= 1'h0;
            if (wready === 1'h1) wvalid <= 1'h0;
        end
        while (bvalid !== 1'h1);
        bready <= 1'h0;
        chk({30'h0, bresp}, {30'h0, er});
        // One idle edge so the next call never re-raises bready in this step
        @(posedge clk);
    endtask
    task automatic axr(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do
        begin
            @(posedge clk);
            if (arready === 1'h1) arvalid <= 1'h0;
        end
        while (rvalid !== 1'h1);
        rready <= 1'h0;
        rdVal = rdata;
        respVal = rresp;
        @(posedge clk);
    endtask
    task automatic axc(input logic [7:0] a, input logic [31:0] exp);
        axr(a);
        chk(rdVal, exp);
        chk({30'h0, respVal}, {30'h0, RESP_OKAY});
    endtask
    task automatic stat(input logic [31:0] lvl);
        axr(A_STAT);
        chk({11'h0, rdVal[28:8]}, lvl);
    endtask
    // Each tick is one cycle wide with an idle cycle after it
    task automatic tk(input logic w, input logic wq, input logic r, input logic rq, input int n);
        repeat (n)
        begin
            wrTick <= w;
            wrReq <= wq;
            rdTick <= r;
            rdReq <= rq;
            @(posedge clk);
            {wrTick, wrReq, rdTick, rdReq} <= 4'h0;
            @(posedge clk);
        end
    endtask
    // Each write is followed by a bare write tick so the flags catch up
    task automatic wr(input int n);
        repeat (n)
        begin
            tk(1'h1, 1'h1, 1'h0, 1'h0, 1);
            tk(1'h1, 1'h0, 1'h0, 1'h0, 1);
        end
    endtask
    // Straps are captured while master reset is held; offsets are then written to 2 and 3
    task automatic mrst(input logic fts, input logic la);
        flag_timing_select <= fts;
        lookahead_mode <= la;
        master_reset_n <= 1'h0;
        repeat (4) @(posedge clk);
        master_reset_n <= 1'h1;
        repeat (4) @(posedge clk);
        axw(A_EOFS, 32'h2, RESP_OKAY);
        axw(A_FOFS, 32'h3, RESP_OKAY);
    endtask

    // ----------------------------------------
    // Main sequence and timeout
    // ----------------------------------------
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errTotal++;
            final_report();
        end
    end
    initial
    begin
        repeat (6) @(posedge clk);
        nrst <= 1'h1;
        @(posedge clk);
        chk({28'h0, die}, 32'h6);
        axc(A_EOFS, 32'h7F);
        axc(A_FOFS, 32'h7F);
        axr(8'h20);
        chk({30'h0, respVal}, {30'h0, RESP_SLVERR});
        axw(8'h24, 32'h1, RESP_SLVERR);
        // Standard mode, synchronous almost flags
        mrst(1'h1, 1'h0);
        axr(A_STAT);
        chk(rdVal & 32'h30, 32'h20);
        tk(1'h1, 1'h1, 1'h0, 1'h0, 1);
        tk(1'h0, 1'h0, 1'h1, 1'h0, 1);
        fl(emptyAll, 1'h0);
        tk(1'h0, 1'h0, 1'h1, 1'h0, 1);
        fl(emptyAll, 1'h1);
        wr(2);
        fl(almost_empty_indicator_n, 1'h0);
        tk(1'h0, 1'h0, 1'h1, 1'h0, 1);
        fl(almost_empty_indicator_n, 1'h1);
        wr(9);
        fl(almost_full_indicator_n, 1'h1);
        wr(1);
        fl(almost_full_indicator_n, 1'h0);
        markReq <= 1'h1;
        @(posedge clk);
        markReq <= 1'h0;
        retransmitActive <= 1'h1;
        tk(1'h0, 1'h0, 1'h1, 1'h1, 5);
        tk(1'h1, 1'h0, 1'h0, 1'h0, 1);
        fl(almost_full_indicator_n, 1'h0);
        retransmitActive <= 1'h0;
        tk(1'h0, 1'h0, 1'h1, 1'h0, 1);
        fl(almost_full_indicator_n, 1'h0);
        tk(1'h1, 1'h0, 1'h0, 1'h0, 1);
        fl(almost_full_indicator_n, 1'h1);
        wr(8);
        tk(1'h1, 1'h0, 1'h0, 1'h0, 1);
        fl(fullAll, 1'h0);
        tk(1'h1, 1'h1, 1'h0, 1'h0, 1);
        stat(32'h10);
        axr(A_ISTAT);
        chk(rdVal & 32'h2, 32'h2);
        fl(irq, 1'h0);
        axw(A_IMASK, 32'h2, RESP_OKAY);
        repeat (2) @(posedge clk);
        fl(irq, 1'h1);
        axw(A_ISTAT, 32'h2, RESP_OKAY);
        repeat (2) @(posedge clk);
        fl(irq, 1'h0);
        partial_reset_n <= 1'h0;
        repeat (4) @(posedge clk);
        partial_reset_n <= 1'h1;
        repeat (4) @(posedge clk);
        axc(A_EOFS, 32'h2);
        stat(32'h0);
        // Asynchronous almost flags: release on the opposite clock
        mrst(1'h0, 1'h0);
        wr(3);
        fl(almost_empty_indicator_n, 1'h1);
        tk(1'h0, 1'h0, 1'h1, 1'h1, 1);
        tk(1'h0, 1'h0, 1'h1, 1'h0, 1);
        fl(almost_empty_indicator_n, 1'h0);
        wr(11);
        fl(almost_full_indicator_n, 1'h0);
        tk(1'h0, 1'h0, 1'h1, 1'h1, 1);
        tk(1'h0, 1'h0, 1'h1, 1'h0, 1);
        fl(almost_full_indicator_n, 1'h1);
        // Lookahead mode: the output word counts toward every level
        mrst(1'h1, 1'h1);
        tk(1'h1, 1'h1, 1'h0, 1'h0, 1);
        tk(1'h0, 1'h0, 1'h1, 1'h0, 1);
        fl(emptyAll, 1'h1);
        tk(1'h0, 1'h0, 1'h1, 1'h0, 5);
        fl(emptyAll, 1'h0);
        tk(1'h0, 1'h0, 1'h1, 1'h1, 1);
        tk(1'h0, 1'h0, 1'h1, 1'h0, 4);
        fl(emptyAll, 1'h1);
        tk(1'h0, 1'h0, 1'h1, 1'h1, 2);
        stat(32'h0);
        tk(1'h1, 1'h1, 1'h0, 1'h0, 1);
        tk(1'h0, 1'h0, 1'h1, 1'h0, 1);
        wr(2);
        tk(1'h0, 1'h0, 1'h1, 1'h0, 1);
        fl(almost_empty_indicator_n, 1'h0);
        chk({30'h0, paeEach}, 32'h0);
        wr(1);
        tk(1'h0, 1'h0, 1'h1, 1'h0, 1);
        fl(almost_empty_indicator_n, 1'h1);
        wr(9);
        fl(almost_full_indicator_n, 1'h1);
        wr(1);
        fl(almost_full_indicator_n, 1'h0);
        chk({30'h0, pafEach}, 32'h0);
        final_report();
    end
endmodule
